// >>> bench/fkp_flash_key_protect_props.sv
// Checker of the flash key and protect slice.
// Assumes a bind onto fkp_flash_key_protect on one clock.
`default_nettype none
module fkp_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic op_start,
  input wire logic [31:0] op_address,
  input wire logic [31:0] read_address,
  input wire logic [31:0] erase_target_address,
  input wire logic boot_pages_write_enable,
  input wire logic info_block_read_enable,
  input wire logic read_block,
  input wire logic op_protected,
  input wire logic protect_violation_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire wa = reg_write && reg_addr == 8'h10;
  wire wb = reg_write && reg_addr == 8'h14;
  wire wi = reg_write && reg_addr == 8'h18;
  // Tracks whether each key register holds a valid first word, so an unlock is only expected after one.
  logic boot_half;
  logic info_half;
  always @(posedge clk_sys) begin
    if (reset) begin
      boot_half <= 1'b0;
      info_half <= 1'b0;
    end else begin
      if (wb) begin
        boot_half <= !boot_half && reg_wdata == 32'h45670123;
      end
      if (wi) begin
        info_half <= !info_half && reg_wdata == 32'h896DBA23;
      end
    end
  end
  property p_key_read; reg_read && (reg_addr == 8'h14 || reg_addr == 8'h18) |=> reg_rdata == 32'h0; endproperty
  a_key_read: assert property (p_key_read) else $error("key read not zero");
  property p_addr_wr; wa |=> erase_target_address == $past(reg_wdata); endproperty
  a_addr_wr: assert property (p_addr_wr) else $error("erase address not written");
  property p_addr_hold; !wa |=> $stable(erase_target_address); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("erase address changed");
  property p_boot; wb && boot_half && reg_wdata == 32'hCDEF89AB |-> ##2 boot_pages_write_enable; endproperty
  a_boot: assert property (p_boot) else $error("boot unlock missed");
  property p_info; wi && info_half && reg_wdata == 32'h7EA56C8F |-> ##2 info_block_read_enable; endproperty
  a_info: assert property (p_info) else $error("info unlock missed");
  property p_restart; !boot_pages_write_enable && wb && reg_wdata == 32'h45670123 ##1 wb && reg_wdata != 32'hCDEF89AB
    ##1 wb && reg_wdata == 32'hCDEF89AB |-> ##2 !boot_pages_write_enable; endproperty
  a_restart: assert property (p_restart) else $error("broken key pair unlocked");
  property p_page; op_address[16:9] < 8'h04 && !boot_pages_write_enable |-> op_protected; endproperty
  a_page: assert property (p_page) else $error("boot page unguarded");
  property p_viol; op_start && op_protected |=> protect_violation_flag; endproperty
  a_viol: assert property (p_viol) else $error("violation not flagged");
  property p_blk; info_block_read_enable && read_address >= 32'h00020200 && read_address <= 32'h000203FF |-> !read_block;
  endproperty
  a_blk: assert property (p_blk) else $error("info block still blocked");
endmodule
bind fkp_flash_key_protect fkp_chk u_fkp_chk (.*);
`default_nettype wire

// >>> bench/test_flash_key_and_protect_regs.sv
// Self-checking bench of the flash key and protect slice.
// Assumes fkp_flash_key_protect with the checker bound.
`default_nettype none
module test_flash_key_and_protect_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, reset = 1, reg_write = 0, reg_read = 0, cfg_load = 0, guard_load = 0, op_start = 0;
  logic read_protect_in = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, cfg_word = 0, cfg_word_inv = 0, guard_load_word0 = 0, guard_load_word1 = 0;
  logic [31:0] op_address = 0, read_address = 0, ea, v;
  logic [2:0] cfg_upper_bits = 0;
  logic [63:0] g;
  logic [31:0] tab [4] = '{32'h000201FF, 32'h00020200, 32'h000203FF, 32'h00020400};
  wire [31:0] reg_rdata, erase_target_address;
  wire boot_pages_write_enable, info_block_read_enable, read_block, op_protected, protect_violation_flag, irq;
  integer err_total = 0, compares = 0, seed = 32'ha2fa, i, p;
  always #2.5 clk_sys = ~clk_sys;
  fkp_flash_key_protect u_fkp_flash_key_protect (.*);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1;
    reg_read <= 0;
  endtask
  task nop(input integer n);
    repeat (n) begin
      @(posedge clk_sys);
      reg_write <= 0;
      reg_read <= 0;
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1;
    reg_write <= 0;
    @(posedge clk_sys);
    reg_read <= 0;
    #1 chk(reg_rdata, e);
  endtask
  task cfgld(input logic [31:0] inv, input logic rp, input logic [2:0] up);
    @(posedge clk_sys);
    cfg_word <= v;
    cfg_word_inv <= inv;
    read_protect_in <= rp;
    cfg_upper_bits <= up;
    cfg_load <= 1;
    @(posedge clk_sys);
    cfg_load <= 0;
  endtask
  task blk(input logic en);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk_sys);
      read_address <= tab[i];
      #1 chk(read_block, !(en && (i == 1 || i == 2)));
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    err_total = err_total + 1;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 0;
    rd(8'h10, 32'h0);
    rd(8'h1C, 32'hFFFFFFFF);
    rd(8'h24, 32'hFFFFFFFF);
    for (i = 0; i < 4; i = i + 1) begin
      ea = $random(seed);
      wr(8'h10, ea);
      rd(8'h10, ea);
    end
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'h0);
    wr(8'h14, 32'h12345678);
    rd(8'h1C, 32'hFFFFFFFF);
    rd(8'h20, 32'hFFFFFFFF);
    rd(8'h14, 32'h0);
    rd(8'h7C, 32'h0);
    $display("done: registers");
    wr(8'h14, 32'h45670123);
    wr(8'h14, 32'h45670123);
    wr(8'h14, 32'hCDEF89AB);
    nop(3);
    #1 chk(boot_pages_write_enable, 0);
    wr(8'h14, 32'h45670123);
    wr(8'h14, 32'hCDEF89AB);
    nop(3);
    #1 chk(boot_pages_write_enable, 1);
    chk(irq, 0);
    wr(8'h3C, 32'h1);
    nop(1);
    #1 chk(irq, 1);
    rd(8'h34, 32'h9);
    wr(8'h38, 32'h1);
    wr(8'h30, 32'h0);
    nop(1);
    #1 chk({irq, boot_pages_write_enable}, 0);
    $display("done: boot key");
    v = $random(seed);
    cfgld(v, 0, 3'h0);
    rd(8'h1C, 32'hFFFFFFE1);
    cfgld(~v, 1, 3'h5);
    rd(8'h1C, 32'hFFFFFFF6);
    blk(0);
    wr(8'h18, 32'h896DBA23);
    wr(8'h18, 32'h7EA56C8F);
    nop(3);
    #1 chk(info_block_read_enable, 1);
    rd(8'h18, 32'h0);
    blk(1);
    $display("done: info key");
    g = {$random(seed), $random(seed)};
    @(posedge clk_sys);
    guard_load_word0 <= g[31:0];
    guard_load_word1 <= g[63:32];
    guard_load <= 1;
    @(posedge clk_sys);
    guard_load <= 0;
    rd(8'h20, g[31:0]);
    rd(8'h24, g[63:32]);
    for (i = 0; i < 24; i = i + 1) begin
      p = (i == 0) ? 127 : (i == 1) ? 64 : $random(seed) & 255;
      @(posedge clk_sys);
      op_address <= p << 9;
      #1 chk(op_protected, (p < 128 && !g[p / 2]) || p < 4);
    end
    @(posedge clk_sys);
    op_address <= 32'h0;
    op_start <= 1;
    @(posedge clk_sys);
    op_start <= 0;
    rd(8'h40, 32'h10);
    wr(8'h40, 32'h10);
    nop(1);
    #1 chk(protect_violation_flag, 0);
    $display("done: guards");
    @(posedge clk_sys);
    reset <= 1;
    repeat (2) @(posedge clk_sys);
    reset <= 0;
    rd(8'h20, 32'hFFFFFFFF);
    chk(erase_target_address, 0);
    chk(info_block_read_enable, 0);
    $display("done: reset");
    end_of_test;
  end
endmodule
`default_nettype wire

// >>> hw/fkp_flash_key_protect.v
// Flash key and protect register slice: erase address, key registers, config status, guard words.
// Assumes a simple register port on clk_sys and system loading logic that presents option bytes with a strobe.
//
// The plain strobed port was chosen for this implementation.
`default_nettype none
`include "fkp_regs.vh"
module fkp_flash_key_protect (
  input wire clk_sys,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  input wire cfg_load,
  input wire [31:0] cfg_word,
  input wire [31:0] cfg_word_inv,
  input wire read_protect_in,
  input wire [2:0] cfg_upper_bits,
  input wire guard_load,
  input wire [31:0] guard_load_word0,
  input wire [31:0] guard_load_word1,
  input wire op_start,
  input wire [31:0] op_address,
  input wire [31:0] read_address,
  output reg [31:0] erase_target_address,
  output wire boot_pages_write_enable,
  output wire info_block_read_enable,
  output wire read_block,
  output wire op_protected,
  output wire protect_violation_flag,
  output wire irq
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Page index of a main-array byte address with 512-byte pages.
  function [7:0] fkp_page_of;
    input [31:0] addr;
    begin
      fkp_page_of = addr[16:9];
    end
  endfunction
  // Guard bit for a page: 64 pair bits across two words.
  function fkp_pair_guard;
    input [63:0] guards;
    input [7:0] page;
    begin
      if (page[7]) begin
        fkp_pair_guard = 1'b1;
      end else begin
        fkp_pair_guard = guards[page[6:1]];
      end
    end
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_erase = reg_write && (reg_addr == `FKP_OFF_ERASE_ADDR);
  wire wr_boot_key = reg_write && (reg_addr == `FKP_OFF_BOOT_KEY);
  wire wr_info_key = reg_write && (reg_addr == `FKP_OFF_INFO_KEY);
  wire wr_ctrl = reg_write && (reg_addr == `FKP_OFF_CTRL);
  wire wr_irq_clear = reg_write && (reg_addr == `FKP_OFF_IRQ_CLEAR);
  wire wr_irq_enable = reg_write && (reg_addr == `FKP_OFF_IRQ_ENABLE);
  wire wr_viol = reg_write && (reg_addr == `FKP_OFF_VIOL_STATUS);

  // ----------------------------------------
  // Key sequence detectors
  // ----------------------------------------
  wire boot_unlocked;
  wire boot_failed;
  wire info_unlocked;
  wire info_failed;
  fkp_key_seq #(
    .KEY1(`FKP_BOOT_KEY1),
    .KEY2(`FKP_BOOT_KEY2)
  ) u_boot_key (
    .clk_sys(clk_sys),
    .reset(reset),
    .write_key(wr_boot_key),
    .key_data(reg_wdata),
    .unlocked(boot_unlocked),
    .failed(boot_failed)
  );
  fkp_key_seq #(
    .KEY1(`FKP_INFO_KEY1),
    .KEY2(`FKP_INFO_KEY2)
  ) u_info_key (
    .clk_sys(clk_sys),
    .reset(reset),
    .write_key(wr_info_key),
    .key_data(reg_wdata),
    .unlocked(info_unlocked),
    .failed(info_failed)
  );

  // ----------------------------------------
  // Erase address
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      erase_target_address <= `FKP_RST_ERASE_ADDR;
    end else if (wr_erase) begin
      erase_target_address <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Control enables
  // ----------------------------------------
  reg boot_we;
  reg info_re;
  always @(posedge clk_sys) begin
    if (reset) begin
      boot_we <= 1'b0;
      info_re <= 1'b0;
    end else begin
      if (boot_unlocked) begin
        boot_we <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[`FKP_BIT_BOOT_WE]) begin
        boot_we <= 1'b0;
      end
      if (info_unlocked) begin
        info_re <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[`FKP_BIT_INFO_RE]) begin
        info_re <= 1'b0;
      end
    end
  end
  assign boot_pages_write_enable = boot_we;
  assign info_block_read_enable = info_re;

  // ----------------------------------------
  // Config status word
  // ----------------------------------------
  reg [4:0] cfg_bits;
  always @(posedge clk_sys) begin
    if (reset) begin
      cfg_bits <= 5'h1F;
    end else if (cfg_load) begin
      cfg_bits <= {cfg_upper_bits, read_protect_in, (cfg_word != ~cfg_word_inv)};
    end
  end
  wire [31:0] cfg_status = {27'h7FFFFFF, cfg_bits};

  // ----------------------------------------
  // Read protection window
  // ----------------------------------------
  wire in_info = (read_address >= `FKP_INFO_LO) && (read_address <= `FKP_INFO_HI);
  assign read_block = cfg_bits[`FKP_BIT_READ_PROTECT] && !(in_info && info_re);

  // ----------------------------------------
  // Guard words
  // ----------------------------------------
  reg [31:0] guard0;
  reg [31:0] guard1;
  always @(posedge clk_sys) begin
    if (reset) begin
      guard0 <= `FKP_RST_GUARD;
      guard1 <= `FKP_RST_GUARD;
    end else if (guard_load) begin
      guard0 <= guard_load_word0;
      guard1 <= guard_load_word1;
    end
  end
  wire [7:0] op_page = fkp_page_of(op_address);
  wire pair_bit = fkp_pair_guard({guard1, guard0}, op_page);
  assign op_protected = (pair_bit == 1'b0) || (op_page < 8'h04 && !boot_we);

  // ----------------------------------------
  // Violation flag
  // ----------------------------------------
  reg viol;
  wire viol_event = op_start && op_protected;
  always @(posedge clk_sys) begin
    if (reset) begin
      viol <= 1'b0;
    end else if (viol_event) begin
      viol <= 1'b1;
    end else if (wr_viol && reg_wdata[`FKP_BIT_VIOL]) begin
      viol <= 1'b0;
    end
  end
  assign protect_violation_flag = viol;

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  reg [3:0] irq_status;
  reg [3:0] irq_enable;
  wire [3:0] irq_events = {boot_failed | info_failed, viol_event, info_unlocked, boot_unlocked};
  always @(posedge clk_sys) begin
    if (reset) begin
      irq_status <= 4'h0;
      irq_enable <= 4'h0;
    end else begin
      irq_status <= irq_events | (irq_status & ~(wr_irq_clear ? reg_wdata[3:0] : 4'h0));
      if (wr_irq_enable) begin
        irq_enable <= reg_wdata[3:0];
      end
    end
  end
  assign irq = |(irq_status & irq_enable);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      `FKP_OFF_ERASE_ADDR: next_rdata = erase_target_address;
      `FKP_OFF_BOOT_KEY: next_rdata = 32'h00000000;
      `FKP_OFF_INFO_KEY: next_rdata = 32'h00000000;
      `FKP_OFF_CFG_STATUS: next_rdata = cfg_status;
      `FKP_OFF_GUARD0: next_rdata = guard0;
      `FKP_OFF_GUARD1: next_rdata = guard1;
      `FKP_OFF_CTRL: next_rdata = {20'h00000, info_re, 2'b00, boot_we, 8'h00};
      `FKP_OFF_IRQ_STATUS: next_rdata = {28'h0000000, irq_status};
      `FKP_OFF_IRQ_ENABLE: next_rdata = {28'h0000000, irq_enable};
      `FKP_OFF_VIOL_STATUS: next_rdata = {27'h0000000, viol, 4'h0};
      default: next_rdata = 32'h00000000;
    endcase
  end
  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// >>> hw/fkp_key_seq.v
// Two-word ordered key detector for one key register.
// Assumes one-cycle write strobes on the system clock.
`default_nettype none
module fkp_key_seq #(
  parameter [31:0] KEY1 = 32'h00000000,
  parameter [31:0] KEY2 = 32'h00000000
) (
  input wire clk_sys,
  input wire reset,
  input wire write_key,
  input wire [31:0] key_data,
  output reg unlocked,
  output reg failed
);
  // ----------------------------------------
  // Sequence state
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_HALF = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;
  reg next_unlocked;
  reg next_failed;
  always @* begin
    next_state = state;
    next_unlocked = 1'b0;
    next_failed = 1'b0;
    case (state)
      ST_IDLE: begin
        if (write_key) begin
          if (key_data == KEY1) begin
            next_state = ST_HALF;
          end else begin
            next_failed = 1'b1;
          end
        end
      end
      ST_HALF: begin
        if (write_key) begin
          next_state = ST_IDLE;
          if (key_data == KEY2) begin
            next_unlocked = 1'b1;
          end else begin
            next_failed = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  always @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      unlocked <= 1'b0;
      failed <= 1'b0;
    end else begin
      state <= next_state;
      unlocked <= next_unlocked;
      failed <= next_failed;
    end
  end
endmodule
`default_nettype wire

// >>> hw/fkp_regs.vh
// Register offsets, field positions, reset values and key words of the flash key and protect slice.
// Assumes inclusion by bare name from the design files of this block.
`ifndef FKP_REGS_VH
`define FKP_REGS_VH
`define FKP_OFF_ERASE_ADDR 8'h10
`define FKP_OFF_BOOT_KEY 8'h14
`define FKP_OFF_INFO_KEY 8'h18
`define FKP_OFF_CFG_STATUS 8'h1C
`define FKP_OFF_GUARD0 8'h20
`define FKP_OFF_GUARD1 8'h24
`define FKP_OFF_CTRL 8'h30
`define FKP_OFF_IRQ_STATUS 8'h34
`define FKP_OFF_IRQ_CLEAR 8'h38
`define FKP_OFF_IRQ_ENABLE 8'h3C
`define FKP_OFF_VIOL_STATUS 8'h40
`define FKP_RST_ERASE_ADDR 32'h00000000
`define FKP_RST_CFG 32'hFFFFFFFF
`define FKP_RST_GUARD 32'hFFFFFFFF
`define FKP_BOOT_KEY1 32'h45670123
`define FKP_BOOT_KEY2 32'hCDEF89AB
`define FKP_INFO_KEY1 32'h896DBA23
`define FKP_INFO_KEY2 32'h7EA56C8F
`define FKP_INFO_LO 32'h00020200
`define FKP_INFO_HI 32'h000203FF
`define FKP_BIT_CFG_MISMATCH 0
`define FKP_BIT_READ_PROTECT 1
`define FKP_BIT_BOOT_WE 8
`define FKP_BIT_INFO_RE 11
`define FKP_BIT_VIOL 4
`define FKP_IRQ_BOOT_UNLOCK 0
`define FKP_IRQ_INFO_UNLOCK 1
`define FKP_IRQ_VIOLATION 2
`define FKP_IRQ_KEY_FAIL 3
`endif
